// ---- include/aicc_consts.svh ----
`ifndef AICC_CONSTS_SVH
`define AICC_CONSTS_SVH
// Behaviour
// - Clock ratio select is bits 2:0 of input_clock_config, reset 111.
// - Sample rates 32, 44.1, 48, 88.2, 96, 176.4 and 192 kHz are accepted.
// - Internal clock is 32.768, 45.1584 or 49.152 MHz by rate family.
// - Select 111 or 110 takes the bit clock as source, else crystal clock.
// - Rate field 00 gives 768,512,384,256,128,576 fs; 111 is 64 fs; 110 none.
// - Rate 01 gives 384..64 fs, 1X half that; 101 none; 110 32 fs; 111 64 fs.
// - First stage rate field is bits 4:3 of input_clock_config, reset 00.
// - Rate 00 oversamples 2x, 01 passes through, 10 downsamples 2x.
// - Bit 7 of input_clock_config, reset 0, set disables fault recovery.
// - Low fault input drives tri-state low for recovery time, then high.
// - Low-then-high recovery cycle repeats while fault stays low.
// - Device is always slave; master drives frame, bit clock and data.
// - Format bits 3:0 plus bit order flag bit 4 pick the serial format.
// - serial_input_format holds maps, delay, order, format; reset 0x80.
// - input_clock_config bits 6:5 are reserved and read as one.
// - Frame rate off by more than four, or PLL unlocked, mutes: samples zeroed, valid held low.
`define AICC_ADDR_CLK_CFG   8'h00
`define AICC_ADDR_FMT       8'h01
`define AICC_CLK_CFG_RST    8'h67
`define AICC_FMT_RST        8'h80
`define AICC_RSVD_MASK      8'h60
`define AICC_RECOV_DIS_BIT  7
`define AICC_RATE_MSB       4
`define AICC_RATE_LSB       3
`define AICC_SEL_MSB        2
`define AICC_SEL_LSB        0
`define AICC_CH2_BIT        7
`define AICC_CH1_BIT        6
`define AICC_DLY_BIT        5
`define AICC_ORDER_BIT      4
`define AICC_FMT_MSB        3
`define AICC_FMT_LSB        0
`define AICC_RATIO_IR0      {10'h240, 10'h080, 10'h100, 10'h180, 10'h200, 10'h300}
`define AICC_RATIO_IR1      {10'h040, 10'h080, 10'h0C0, 10'h100, 10'h180}
`define AICC_RATIO_BCK64    10'h040
`define AICC_RATIO_BCK32    10'h020
`define AICC_CLK_NS         10
`define AICC_TICK_NS        100000
`define AICC_TIME_MAX       14'h2710
`define AICC_DESYNC_TOL     13'h0004
`define AICC_P_32K          13'h0A88
`define AICC_P_44K          13'h087F
`define AICC_P_48K          13'h0648
`define AICC_P_88K          13'h043F
`define AICC_P_96K          13'h0323
`define AICC_P_176K         13'h021F
`define AICC_ICLK_32        19'h50000
`define AICC_ICLK_44        19'h6E400
`define AICC_ICLK_48        19'h78000
`endif

// ---- include/aicc_pkg.sv ----
package aicc_pkg;
   typedef enum logic [2:0] {
      FR_IDLE    = 3'b001,
      FR_HOLD    = 3'b010,
      FR_RELEASE = 3'b100
   } aicc_fault_e;
   typedef logic [23:0] aicc_sample_t;
endpackage

// ---- src/aicc_rx.sv ----
`timescale 1ns/100ps
`default_nettype none
module aicc_rx (
   input  wire logic                  bit_clock_input,
   input  wire logic                  reset,
   input  wire logic                  frame_clock_input,
   input  wire logic                  serial_data_input,
   input  wire logic [3:0]            serial_format_select,
   input  wire logic                  bit_order_flag,
   output var  aicc_pkg::aicc_sample_t left_word,
   output var  aicc_pkg::aicc_sample_t right_word,
   output logic                       pair_toggle
);
   import aicc_pkg::*;
   logic [4:0]   cfg_s1, cfg_s2;
   logic         frame_d;
   aicc_sample_t acc, acc_in, fin_acc, word;
   logic [4:0]   cnt, cnt_in, fin_cnt, n;
   logic         i2s, rj, lsb_first, edge_seen, take;

   // Format is quasi-static; change it only while the link is idle
   always_ff @(posedge bit_clock_input or posedge reset) begin
      if (reset) begin
         cfg_s1 <= 5'h00;
         cfg_s2 <= 5'h00;
      end else begin
         cfg_s1 <= {bit_order_flag, serial_format_select};
         cfg_s2 <= cfg_s1;
      end
   end

   assign i2s       = (cfg_s2[1:0] == 2'h0);
   assign rj        = (cfg_s2[1:0] == 2'h2);
   assign lsb_first = cfg_s2[4];
   assign edge_seen = (frame_clock_input != frame_d);
   // Right-justified format keeps shifting so the last bits before the edge count
   assign take      = rj || (cnt < 5'h18);

   always_comb begin
      acc_in  = lsb_first ? {serial_data_input, acc[23:1]} : {acc[22:0], serial_data_input};
      cnt_in  = (cnt < 5'h18) ? cnt + 5'h01 : cnt;
      if (!take) begin
         acc_in = acc;
         cnt_in = cnt;
      end
      fin_acc = i2s ? acc_in : acc;
      fin_cnt = i2s ? cnt_in : cnt;
      case (cfg_s2[3:2])
         2'h0:    n = rj ? 5'h18 : fin_cnt;
         2'h1:    n = rj ? 5'h14 : fin_cnt;
         2'h2:    n = rj ? 5'h12 : fin_cnt;
         default: n = rj ? 5'h10 : fin_cnt;
      endcase
      word = lsb_first ? fin_acc : (fin_acc << (5'h18 - n));
   end

   // Slave only: every edge here is made by the outside master
   always_ff @(posedge bit_clock_input or posedge reset) begin
      if (reset) begin
         frame_d     <= 1'b0;
         acc         <= 24'h000000;
         cnt         <= 5'h00;
         left_word   <= 24'h000000;
         right_word  <= 24'h000000;
         pair_toggle <= 1'b0;
      end else begin
         frame_d <= frame_clock_input;
         if (edge_seen) begin
            acc <= i2s ? 24'h000000 :
                   (lsb_first ? {serial_data_input, 23'h000000} : {23'h000000, serial_data_input});
            cnt <= i2s ? 5'h00 : 5'h01;
            if (i2s ? !frame_d : frame_d) begin
               left_word <= word;
            end else begin
               right_word  <= word;
               pair_toggle <= ~pair_toggle;
            end
         end else begin
            acc <= acc_in;
            cnt <= cnt_in;
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/aicc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "aicc_consts.svh"
module aicc_top #(
   parameter int unsigned TICK_CYCLES = `AICC_TICK_NS / `AICC_CLK_NS
) (
   input  wire logic                  mclk,
   input  wire logic                  reset,
   input  wire logic                  clk_en,
   input  wire logic                  reg_wr,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   output logic [7:0]                 reg_rdata,
   input  wire logic                  bit_clock_input,
   input  wire logic                  frame_clock_input,
   input  wire logic                  serial_data_input,
   input  wire logic                  fault_n,
   input  wire logic [13:0]           fault_recovery_time,
   input  wire logic                  pll_locked,
   input  wire logic                  desync_mute_enable,
   output logic                       bit_clock_source,
   output logic [9:0]                 clock_ratio,
   output logic                       ratio_na,
   output logic [1:0]                 rate_step,
   output logic [2:0]                 rate_index,
   output logic [18:0]                internal_clock,
   output logic                       tristate_n,
   output var  aicc_pkg::aicc_sample_t chan1_sample,
   output var  aicc_pkg::aicc_sample_t chan2_sample,
   output logic                       sample_valid,
   output logic                       mute_active
);
   import aicc_pkg::*;

   localparam logic [59:0] RATIO_IR0 = `AICC_RATIO_IR0;
   localparam logic [49:0] RATIO_IR1 = `AICC_RATIO_IR1;
   localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);

   logic [7:0]   input_clock_config;
   logic [7:0]   serial_input_format;
   logic [2:0]   clock_ratio_select;
   logic [1:0]   first_stage_rate;
   logic         fault_recovery_disable;
   logic         chan_one_map, chan_two_map;
   logic [9:0]   next_ratio;
   logic         next_na;
   logic [1:0]   next_step;

   assign clock_ratio_select     = input_clock_config[`AICC_SEL_MSB:`AICC_SEL_LSB];
   assign first_stage_rate       = input_clock_config[`AICC_RATE_MSB:`AICC_RATE_LSB];
   assign fault_recovery_disable = input_clock_config[`AICC_RECOV_DIS_BIT];
   assign chan_one_map           = serial_input_format[`AICC_CH1_BIT];
   assign chan_two_map           = serial_input_format[`AICC_CH2_BIT];

   // Register port
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         input_clock_config  <= `AICC_CLK_CFG_RST;
         serial_input_format <= `AICC_FMT_RST;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `AICC_ADDR_CLK_CFG: input_clock_config  <= reg_wdata | `AICC_RSVD_MASK;
            `AICC_ADDR_FMT:     serial_input_format <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Unmapped addresses read as zero
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         case (reg_addr)
            `AICC_ADDR_CLK_CFG: reg_rdata <= input_clock_config;
            `AICC_ADDR_FMT:     reg_rdata <= serial_input_format;
            default:            reg_rdata <= 8'h00;
         endcase
      end
   end

   // Expected clock-to-fs ratio; zero with ratio_na where no setting exists
   always_comb begin
      next_ratio = 10'h000;
      next_na    = 1'b0;
      if (clock_ratio_select == 3'h7) begin
         next_ratio = `AICC_RATIO_BCK64;
      end else if (first_stage_rate == 2'h0) begin
         if (clock_ratio_select == 3'h6) begin
            next_na = 1'b1;
         end else begin
            next_ratio = RATIO_IR0[clock_ratio_select * 10 +: 10];
         end
      end else if (clock_ratio_select == 3'h6) begin
         next_ratio = `AICC_RATIO_BCK32;
      end else if (clock_ratio_select == 3'h5) begin
         next_na = 1'b1;
      end else begin
         next_ratio = RATIO_IR1[clock_ratio_select * 10 +: 10];
         if (first_stage_rate[1]) begin
            next_ratio = next_ratio >> 1;
         end
      end
      next_step = first_stage_rate[1] ? 2'h2 : first_stage_rate;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         bit_clock_source <= 1'b1;
         clock_ratio      <= `AICC_RATIO_BCK64;
         ratio_na         <= 1'b0;
         rate_step        <= 2'h0;
      end else if (clk_en) begin
         bit_clock_source <= (clock_ratio_select[2:1] == 2'h3);
         clock_ratio      <= next_ratio;
         ratio_na         <= next_na;
         rate_step        <= next_step;
      end
   end

   // Frame period measured in mclk cycles
   logic [2:0]  fr_sync;
   logic        fr_rise;
   logic [12:0] fr_count, fr_period, fr_diff;
   logic        desync;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fr_sync <= 3'h0;
      end else if (clk_en) begin
         fr_sync <= {fr_sync[1:0], frame_clock_input};
      end
   end

   assign fr_rise = fr_sync[1] & ~fr_sync[2];
   assign fr_diff = (fr_count > fr_period) ? fr_count - fr_period : fr_period - fr_count;

   function automatic logic [2:0] rate_of(input logic [12:0] p);
      if (p > `AICC_P_32K) begin
         rate_of = 3'h0;
      end else if (p > `AICC_P_44K) begin
         rate_of = 3'h1;
      end else if (p > `AICC_P_48K) begin
         rate_of = 3'h2;
      end else if (p > `AICC_P_88K) begin
         rate_of = 3'h3;
      end else if (p > `AICC_P_96K) begin
         rate_of = 3'h4;
      end else if (p > `AICC_P_176K) begin
         rate_of = 3'h5;
      end else begin
         rate_of = 3'h6;
      end
   endfunction

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fr_count  <= 13'h0000;
         fr_period <= 13'h0000;
         desync    <= 1'b1;
      end else if (clk_en) begin
         if (fr_rise) begin
            fr_count  <= 13'h0001;
            fr_period <= fr_count;
            desync    <= (fr_diff > `AICC_DESYNC_TOL);
         end else if (fr_count != 13'h1FFF) begin
            fr_count <= fr_count + 13'h0001;
         end else begin
            // Stopped frame clock counts as lost sync
            desync <= 1'b1;
         end
      end
   end

   // Rate and internal clock follow the last measured frame
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rate_index     <= 3'h0;
         internal_clock <= `AICC_ICLK_32;
      end else if (clk_en && fr_rise) begin
         rate_index <= rate_of(fr_count);
         case (rate_of(fr_count))
            3'h0:             internal_clock <= `AICC_ICLK_32;
            3'h1, 3'h3, 3'h5: internal_clock <= `AICC_ICLK_44;
            default:          internal_clock <= `AICC_ICLK_48;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mute_active <= 1'b0;
      end else if (clk_en) begin
         mute_active <= desync_mute_enable && (desync || !pll_locked);
      end
   end

   // Link side
   aicc_sample_t left_word, right_word;
   logic         pair_toggle;

   aicc_rx u_rx (
      .bit_clock_input      (bit_clock_input),
      .reset                (reset),
      .frame_clock_input    (frame_clock_input),
      .serial_data_input    (serial_data_input),
      .serial_format_select (serial_input_format[`AICC_FMT_MSB:`AICC_FMT_LSB]),
      .bit_order_flag       (serial_input_format[`AICC_ORDER_BIT]),
      .left_word            (left_word),
      .right_word           (right_word),
      .pair_toggle          (pair_toggle)
   );

   // Words stay put for half a frame after the toggle, so they are safe to take
   logic [2:0] tg_sync;
   logic       pair_new;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tg_sync <= 3'h0;
      end else if (clk_en) begin
         tg_sync <= {tg_sync[1:0], pair_toggle};
      end
   end

   assign pair_new = tg_sync[1] ^ tg_sync[2];

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         chan1_sample <= 24'h000000;
         chan2_sample <= 24'h000000;
         sample_valid <= 1'b0;
      end else if (clk_en) begin
         sample_valid <= pair_new && !mute_active;
         if (pair_new) begin
            chan1_sample <= mute_active ? 24'h000000 : (chan_one_map ? right_word : left_word);
            chan2_sample <= mute_active ? 24'h000000 : (chan_two_map ? right_word : left_word);
         end
      end
   end

   // Fault recovery
   logic [1:0]  fault_sync;
   logic        fault_low;
   aicc_fault_e fst;
   logic [13:0] tick_cnt, hold_ticks, load_ticks;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fault_sync <= 2'h3;
      end else if (clk_en) begin
         fault_sync <= {fault_sync[0], fault_n};
      end
   end

   assign fault_low = ~fault_sync[1];
   // Zero would wrap the tick count into a 16384-tick hold, so the shortest time is one tick
   assign load_ticks = (fault_recovery_time == 14'h0000) ? 14'h0001 :
                       (fault_recovery_time > `AICC_TIME_MAX) ? `AICC_TIME_MAX :
                       fault_recovery_time;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fst        <= FR_IDLE;
         tristate_n <= 1'b1;
         tick_cnt   <= 14'h0000;
         hold_ticks <= 14'h0000;
      end else if (clk_en) begin
         case (fst)
            FR_IDLE: begin
               if (fault_low && !fault_recovery_disable) begin
                  fst        <= FR_HOLD;
                  tristate_n <= 1'b0;
                  tick_cnt   <= TICK_LAST;
                  hold_ticks <= load_ticks;
               end
            end
            FR_HOLD: begin
               if (tick_cnt != 14'h0000) begin
                  tick_cnt <= tick_cnt - 14'h0001;
               end else if (hold_ticks != 14'h0001) begin
                  tick_cnt   <= TICK_LAST;
                  hold_ticks <= hold_ticks - 14'h0001;
               end else begin
                  fst        <= FR_RELEASE;
                  tristate_n <= 1'b1;
               end
            end
            FR_RELEASE: begin
               if (fault_low && !fault_recovery_disable) begin
                  fst        <= FR_HOLD;
                  tristate_n <= 1'b0;
                  tick_cnt   <= TICK_LAST;
                  hold_ticks <= load_ticks;
               end else begin
                  fst <= FR_IDLE;
               end
            end
            default: begin
               fst        <= FR_IDLE;
               tristate_n <= 1'b1;
            end
         endcase
      end
   end

   // Checks
   sequence fault_seen;
      clk_en && fault_low && !fault_recovery_disable;
   endsequence

   sequence hold_entered;
      (fst == FR_HOLD) && !tristate_n;
   endsequence

   chk_src_select: assert property (@(posedge mclk) disable iff (reset)
      clk_en |=> bit_clock_source == ($past(clock_ratio_select) >= 3'h6))
      else $error("clock source does not follow the ratio select");

   chk_ratio_none: assert property (@(posedge mclk) disable iff (reset)
      clk_en && first_stage_rate == 2'h0 && clock_ratio_select == 3'h6 |=> ratio_na)
      else $error("ratio select 110 at rate 00 not flagged");

   chk_ratio_top: assert property (@(posedge mclk) disable iff (reset)
      clk_en && first_stage_rate == 2'h0 && clock_ratio_select == 3'h0 |=>
      clock_ratio == 10'h300 && !ratio_na)
      else $error("ratio 768 fs expected");

   chk_ratio_half: assert property (@(posedge mclk) disable iff (reset)
      clk_en && first_stage_rate[1] && clock_ratio_select == 3'h2 |=> clock_ratio == 10'h060)
      else $error("ratio 96 fs expected");

   chk_step_code: assert property (@(posedge mclk) disable iff (reset)
      clk_en && first_stage_rate == 2'h3 |=> rate_step == 2'h2)
      else $error("rate 11 must downsample");

   chk_reg_reset: assert property (@(posedge mclk)
      $fell(reset) |-> input_clock_config == 8'h67 && serial_input_format == 8'h80)
      else $error("register reset values wrong");

   chk_fault_hold: assert property (@(posedge mclk) disable iff (reset)
      (fst == FR_IDLE) ##0 fault_seen |=> hold_entered ##1 !tristate_n)
      else $error("fault did not start a held recovery");

   chk_fault_bypass: assert property (@(posedge mclk) disable iff (reset)
      fst == FR_IDLE && fault_recovery_disable |=> tristate_n)
      else $error("recovery ran while disabled");

   chk_fault_repeat: assert property (@(posedge mclk) disable iff (reset)
      (fst == FR_RELEASE) ##0 fault_seen |-> tristate_n ##1 hold_entered)
      else $error("recovery did not repeat under fault");

   chk_mute_lock: assert property (@(posedge mclk) disable iff (reset)
      clk_en && desync_mute_enable && !pll_locked |=> mute_active ##1 !sample_valid)
      else $error("unlocked PLL did not mute");
endmodule
`default_nettype wire

// ---- dv/aicc_audio_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module aicc_audio_master (
   input  wire logic        go,
   input  wire logic        lsb_first,
   input  wire logic        left_just,
   input  wire logic        right_just,
   input  wire logic [23:0] left,
   input  wire logic [23:0] right,
   output logic             bclk,
   output logic             lrck,
   output logic             sdata,
   output logic             busy
);
   int pos;
   initial begin
      bclk = 1'b0;
      lrck = 1'b1;
      sdata = 1'b0;
      busy = 1'b0;
      #3.7;
      forever begin
         @(posedge go);
         busy = 1'b1;
         // Fourth frame only opens, so the third right word is closed
         for (int f = 0; f < 4; f++) begin
            for (int ch = 0; ch < 2; ch++) begin
               for (int b = 0; b < 32; b++) begin
                  if (f == 3 && (ch == 1 || b > 3)) break;
                  lrck = left_just ? (ch == 0) : (ch == 1);
                  // Right-justified puts the word in the last 24 slots
                  pos = right_just ? b - 8 : (left_just ? b : b - 1);
                  if (pos >= 0 && pos < 24) begin
                     pos = lsb_first ? pos : 23 - pos;
                     sdata = (ch == 1) ? right[pos] : left[pos];
                  end else begin
                     sdata = ~sdata; // Pad bits toggle, no stale level
                  end
                  #6 bclk = 1'b1;
                  #6 bclk = 1'b0; // 64 bit clocks per frame
               end
            end
         end
         busy = 1'b0; // Bit clock stands still between bursts
      end
   end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import aicc_pkg::*;
   localparam int TICK = 4;
   localparam logic [9:0] base_t [5] = '{10'h300, 10'h200, 10'h180, 10'h100, 10'h080};
   logic mclk = 1'b0, reset, clk_en, reg_wr, go, lsb, lj, bclk, lrck, sdata, busy_m;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic fault_n, pll_locked, desync_mute_enable, bit_clock_source, ratio_na, rjm;
   logic [13:0] fault_recovery_time;
   logic [9:0] clock_ratio;
   logic [1:0] rate_step;
   logic [2:0] rate_index;
   logic [18:0] internal_clock;
   logic tristate_n, sample_valid, mute_active;
   aicc_sample_t chan1_sample, chan2_sample;
   int error_cnt = 0, checks_done = 0, cyc = 0, vcnt = 0;
   always #5 mclk = ~mclk;
   aicc_top #(.TICK_CYCLES(TICK)) dut (.mclk(mclk), .reset(reset), .clk_en(clk_en),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .bit_clock_input(bclk), .frame_clock_input(lrck), .serial_data_input(sdata),
      .fault_n(fault_n), .fault_recovery_time(fault_recovery_time), .pll_locked(pll_locked),
      .desync_mute_enable(desync_mute_enable), .bit_clock_source(bit_clock_source),
      .clock_ratio(clock_ratio), .ratio_na(ratio_na), .rate_step(rate_step),
      .rate_index(rate_index), .internal_clock(internal_clock), .tristate_n(tristate_n),
      .chan1_sample(chan1_sample), .chan2_sample(chan2_sample),
      .sample_valid(sample_valid), .mute_active(mute_active));
   aicc_audio_master master (.go(go), .lsb_first(lsb), .left_just(lj), .right_just(rjm),
      .left(24'hA5C3F1),
      .right(24'h3C5A96), .bclk(bclk), .lrck(lrck), .sdata(sdata), .busy(busy_m));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk);
      reg_addr = a;
      @(negedge mclk);
      check("reg_rdata", reg_rdata, exp);
   endtask
   // Three frames of one pair, then compare what reached the processing side
   task automatic run(input logic [7:0] f, input logic l1, input logic [1:0] j,
                      input logic [23:0] e1, input logic [23:0] e2);
      int n, v0;
      wr(8'h01, f);
      lsb = l1;
      lj = j[0];
      rjm = j[1];
      v0 = vcnt;
      tick(1);
      go = 1'b1;
      tick(1);
      go = 1'b0;
      n = 0;
      while (busy_m === 1'b1 && n < 1000) begin
         tick(1);
         n++;
      end
      tick(10);
      check("pairs", vcnt > v0, 1);
      check("chan1", chan1_sample, e1);
      check("chan2", chan2_sample, e2);
   endtask
   function automatic logic [9:0] exp_ratio(input logic [1:0] r, input logic [2:0] s);
      if (s == 3'h7) return 10'h040;
      if (s == 3'h6) return (r == 2'h0) ? 10'h000 : 10'h020;
      if (s == 3'h5) return (r == 2'h0) ? 10'h240 : 10'h000;
      return base_t[s] >> ((r == 2'h0) ? 0 : (r == 2'h1) ? 1 : 2);
   endfunction
   always @(posedge mclk) begin
      cyc++;
      if (sample_valid === 1'b1) vcnt++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      logic [9:0] e;
      int n;
      int lows;
      {reset, clk_en, reg_wr, reg_addr, reg_wdata, go, lsb, lj, rjm} = {2'b11, 21'h000000};
      {fault_n, pll_locked, desync_mute_enable, fault_recovery_time} = {3'b110, 14'h0001};
      repeat (6) @(posedge mclk);
      @(negedge mclk) reset = 1'b0;
      rd(8'h00, 8'h67);
      rd(8'h01, 8'h80);
      rd(8'h05, 8'h00);
      check("src", bit_clock_source, 1);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h60);
      clk_en = 1'b0;
      wr(8'h01, 8'h55);
      clk_en = 1'b1;
      rd(8'h01, 8'h80);
      for (int r = 0; r < 4; r++) begin
         for (int s = 0; s < 8; s++) begin
            wr(8'h00, {3'h3, r[1:0], s[2:0]});
            tick(2);
            e = exp_ratio(r[1:0], s[2:0]);
            check("ratio", clock_ratio, e);
            check("na", ratio_na, e == 10'h000);
            check("src", bit_clock_source, s[2:1] == 2'h3);
            check("step", rate_step, r[1] ? 2'h2 : r[1:0]);
         end
      end
      wr(8'h00, 8'h67);
      run(8'h80, 1'b0, 1'b0, 24'hA5C3F1, 24'h3C5A96);
      check("rate", rate_index, 3'h6);
      check("iclk", internal_clock, 19'h78000);
      run(8'h90, 1'b1, 1'b0, 24'hA5C3F1, 24'h3C5A96);
      run(8'h81, 1'b0, 1'b1, 24'hA5C3F1, 24'h3C5A96);
      run(8'h82, 1'b0, 2'h3, 24'hA5C3F1, 24'h3C5A96);
      run(8'h8E, 1'b0, 2'h3, 24'hC3F100, 24'h5A9600);
      run(8'h40, 1'b0, 1'b0, 24'h3C5A96, 24'hA5C3F1);
      desync_mute_enable = 1'b1;
      pll_locked = 1'b0;
      tick(3);
      check("mute", mute_active, 1);
      {pll_locked, desync_mute_enable} = 2'b10;
      tick(3);
      check("mute", mute_active, 0);
      for (int t = 1; t < 3; t++) begin
         fault_recovery_time = t[13:0];
         fault_n = 1'b0;
         n = 0;
         while (tristate_n !== 1'b0 && n < 50) begin
            tick(1);
            n++;
         end
         n = 0;
         while (tristate_n === 1'b0 && n < 50) begin
            tick(1);
            n++;
         end
         check("hold", n, t * TICK);
         tick(1);
         check("rehold", tristate_n, 0);
         fault_n = 1'b1;
         tick(30);
      end
      wr(8'h00, 8'hE7);
      fault_n = 1'b0;
      lows = 0;
      repeat (20) begin
         tick(1);
         lows += (tristate_n !== 1'b1);
      end
      check("blocked", lows, 0);
      fault_n = 1'b1;
      tally_and_finish();
   end
endmodule
`default_nettype wire
